// File: hdl/capture_pkg.sv
package capture_pkg;
  localparam int PIX_W = 24;
  localparam int BUF_BYTES = 4096;
  localparam int BYTES_PER_WORD = 4;
  localparam int BUF_DEPTH = BUF_BYTES / BYTES_PER_WORD;
  localparam int MIN_LINE_UP = 4;
  localparam int MIN_LINE_DEC = 9;
  localparam logic [23:0] PIX_RST = 24'h000000;
  typedef enum logic [1:0] {
    MODE_PASS,
    MODE_RGB2YUV,
    MODE_YUV2RGB
  } conv_mode_type;
endpackage

// File: hdl/video_capture_port.sv
`timescale 1ns/1ps
module video_capture_port
  import capture_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic multi_chan_i,
  input wire logic pix_valid_i,
  input wire logic [23:0] pix_data_i,
  input wire logic pix_eol_i,
  input wire logic ovf_clear_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [23:0] out_data_o,
  output logic ovf_event_o,
  output logic ovf_flag_o,
  output logic short_line_o
);
  localparam int AW = $clog2(DEPTH);
  conv_mode_type mode;
  assign mode = conv_mode_type'(mode_i);

  // Stage 1: colour-space matrix or pass-through, one cycle
  logic s1_valid_ff, nxt_s1_valid;
  logic [23:0] s1_data_ff, nxt_s1_data;
  logic s1_chroma_ff, nxt_s1_chroma;
  logic phase_ff, nxt_phase;
  logic [3:0] len_ff, nxt_len;
  logic short_ff, nxt_short;
  logic [23:0] stg_ff, nxt_stg;

  function automatic logic [7:0] clip(input logic signed [11:0] x);
    clip = (x < 0) ? 8'h00 : (x > 255) ? 8'hFF : x[7:0];
  endfunction

  // Simple shift-add matrices trade accuracy for one-cycle timing
  function automatic logic [23:0] rgb2yuv(input logic [23:0] p);
    logic signed [11:0] rr, gg, bb, yy, cb, cr;
    rr = {4'h0, p[23:16]};
    gg = {4'h0, p[15:8]};
    bb = {4'h0, p[7:0]};
    yy = (rr + (gg <<< 1) + bb) >>> 2;
    cb = ((bb - yy) >>> 1) + 12'sh080;
    cr = ((rr - yy) >>> 1) + 12'sh080;
    rgb2yuv = {clip(yy), clip(cb), clip(cr)};
  endfunction

  function automatic logic [23:0] yuv2rgb(input logic [23:0] p);
    logic signed [11:0] yy, cb, cr, rr, gg, bb;
    yy = {4'h0, p[23:16]};
    cb = {4'h0, p[15:8]} - 12'sh080;
    cr = {4'h0, p[7:0]} - 12'sh080;
    rr = yy + (cr <<< 1);
    bb = yy + (cb <<< 1);
    gg = yy - (cr >>> 1) - (cb >>> 1);
    yuv2rgb = {clip(rr), clip(gg), clip(bb)};
  endfunction

  // Buffer side signals
  logic buf_ready;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [23:0] mem [DEPTH];
  logic ovf_ev_ff, nxt_ovf_ev, ovf_flag_ff, nxt_ovf_flag;
  logic push, pop, full, fetch;

  // Input is never stalled: the source cannot be held, so a full buffer drops
  always_comb begin
    nxt_s1_valid = pix_valid_i;
    nxt_s1_data = s1_data_ff;
    nxt_s1_chroma = s1_chroma_ff;
    nxt_phase = phase_ff;
    nxt_len = len_ff;
    // A line ending in the clear cycle still sets the flag
    nxt_short = ovf_clear_i ? 1'b0 : short_ff;
    nxt_stg = stg_ff;
    if (pix_valid_i) begin
      unique case (mode)
        MODE_RGB2YUV: begin
          nxt_s1_data = rgb2yuv(pix_data_i);
          nxt_s1_chroma = phase_ff;
        end
        MODE_YUV2RGB: begin
          // 16-bit Y/C pairs are upsampled by holding Cb of the pair; the first pixel uses centred Cr
          if (!phase_ff) begin
            nxt_stg = {pix_data_i[15:8], pix_data_i[7:0], 8'h80};
          end else begin
            nxt_stg = {pix_data_i[15:8], stg_ff[15:8], pix_data_i[7:0]};
          end
          nxt_s1_data = yuv2rgb({pix_data_i[15:8],
                                 phase_ff ? stg_ff[15:8] : pix_data_i[7:0],
                                 phase_ff ? pix_data_i[7:0] : 8'h80});
          nxt_s1_chroma = 1'b0;
        end
        default: begin
          nxt_s1_data = pix_data_i;
          nxt_s1_chroma = 1'b0;
        end
      endcase
      nxt_phase = pix_eol_i ? 1'b0 : !phase_ff;
      nxt_len = pix_eol_i ? 4'h0 : (len_ff == 4'hF ? len_ff : len_ff + 4'h1);
      // flag single-channel lines too short for the active converter
      if (pix_eol_i && !multi_chan_i) begin
        if (mode == MODE_RGB2YUV && len_ff < 4'(MIN_LINE_DEC - 1))
          nxt_short = 1'b1;
        if (mode == MODE_YUV2RGB && len_ff < 4'(MIN_LINE_UP - 1))
          nxt_short = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1_valid_ff <= 1'b0;
      s1_data_ff <= PIX_RST;
      s1_chroma_ff <= 1'b0;
      phase_ff <= 1'b0;
      len_ff <= 4'h0;
      short_ff <= 1'b0;
      stg_ff <= PIX_RST;
    end else begin
      s1_valid_ff <= nxt_s1_valid;
      s1_data_ff <= nxt_s1_data;
      s1_chroma_ff <= nxt_s1_chroma;
      phase_ff <= nxt_phase;
      len_ff <= nxt_len;
      short_ff <= nxt_short;
      stg_ff <= nxt_stg;
    end
  end

  // Decimator keeps luma per pixel and alternates Cb/Cr across the pair
  logic [23:0] dec_data;
  always_comb begin
    dec_data = s1_data_ff;
    if (mode == MODE_RGB2YUV) begin
      dec_data = {8'h00, s1_data_ff[23:16],
                  s1_chroma_ff ? s1_data_ff[7:0] : s1_data_ff[15:8]};
    end
  end

  // staging buffer of 4 kilobytes, one pixel per 32-bit word
  assign full = (cnt_ff == (AW+1)'(DEPTH));
  assign buf_ready = !full;
  assign push = s1_valid_ff && buf_ready;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    nxt_wp = push ? wp_ff + AW'(1) : wp_ff;
    nxt_rp = fetch ? rp_ff + AW'(1) : rp_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(fetch);
    nxt_ovf_ev = s1_valid_ff && full;
    nxt_ovf_flag = ovf_flag_ff;
    if (ovf_clear_i)
      nxt_ovf_flag = 1'b0;
    if (nxt_ovf_ev)
      nxt_ovf_flag = 1'b1;
  end

  always_ff @(posedge clock_i) begin
    if (push)
      mem[wp_ff] <= dec_data;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      ovf_ev_ff <= 1'b0;
      ovf_flag_ff <= 1'b0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
      ovf_ev_ff <= nxt_ovf_ev;
      ovf_flag_ff <= nxt_ovf_flag;
    end
  end

  // Two-entry output skid buffer so a writer stall loses no word
  logic [23:0] sk0_ff, nxt_sk0, sk1_ff, nxt_sk1;
  logic [1:0] sk_cnt_ff, nxt_sk_cnt;
  logic [23:0] mem_q;
  // Words leave the memory only as the skid accepts them, so count tracks
  assign mem_q = mem[rp_ff];
  assign fetch = (cnt_ff != '0) && (sk_cnt_ff != 2'h2 || pop);

  assign out_valid_o = (sk_cnt_ff != 2'h0);
  assign out_data_o = sk0_ff;

  always_comb begin
    nxt_sk_cnt = sk_cnt_ff + 2'(fetch) - 2'(pop);
    nxt_sk0 = pop ? sk1_ff : sk0_ff;
    nxt_sk1 = sk1_ff;
    if (fetch) begin
      if (nxt_sk_cnt == 2'h1)
        nxt_sk0 = mem_q;
      else
        nxt_sk1 = mem_q;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sk_cnt_ff <= 2'h0;
      sk0_ff <= PIX_RST;
      sk1_ff <= PIX_RST;
    end else begin
      sk_cnt_ff <= nxt_sk_cnt;
      sk0_ff <= nxt_sk0;
      sk1_ff <= nxt_sk1;
    end
  end

  assign ovf_event_o = ovf_ev_ff;
  assign ovf_flag_o = ovf_flag_ff;
  assign short_line_o = short_ff;

  property p_ovf_cause;
    @(posedge clock_i) disable iff (rst_i)
      ovf_event_o |-> $past(full) && $past(s1_valid_ff);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause)
    else $error("overflow without full buffer");

  property p_flag_sticky;
    @(posedge clock_i) disable iff (rst_i)
      ovf_event_o |=> ovf_flag_o;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag not latched");

  property p_no_push_full;
    @(posedge clock_i) disable iff (rst_i)
      full |-> !push;
  endproperty
  a_no_push_full: assert property (p_no_push_full)
    else $error("write into full buffer");

  property p_stable_out;
    @(posedge clock_i) disable iff (rst_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
  endproperty
  a_stable_out: assert property (p_stable_out)
    else $error("output word lost under stall");

  property p_no_ovf_room;
    @(posedge clock_i) disable iff (rst_i)
      s1_valid_ff && !full |=> !ovf_event_o;
  endproperty
  a_no_ovf_room: assert property (p_no_ovf_room)
    else $error("overflow while buffer had room");

  property p_short_cause;
    @(posedge clock_i) disable iff (rst_i)
      $rose(short_line_o) |-> $past(pix_valid_i && pix_eol_i && !multi_chan_i);
  endproperty
  a_short_cause: assert property (p_short_cause)
    else $error("short line flagged outside single-channel line end");
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import capture_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] mode_i = 2'h0;
  logic multi_chan_i = 1'b0;
  logic ovf_clear_i = 1'b0;
  logic out_ready_i = 1'b0;
  logic pix_valid_i, pix_eol_i, out_valid_o, ovf_event_o;
  logic ovf_flag_o, short_line_o;
  logic [23:0] pix_data_i, out_data_o;
  logic [23:0] got[$];
  int ovf_cnt = 0;
  int bad_count = 0;
  int comparisons = 0;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
  always #2 clock_i = ~clock_i;
  video_source video_source_inst (.clock_i(clock_i),
    .pix_valid_o(pix_valid_i), .pix_data_o(pix_data_i),
    .pix_eol_o(pix_eol_i));
  // Tiny buffer so that a short stall already overflows it
  video_capture_port #(.DEPTH(4)) video_capture_port_inst (.clock_i,
    .rst_i, .mode_i, .multi_chan_i, .pix_valid_i, .pix_data_i,
    .pix_eol_i, .ovf_clear_i, .out_valid_o, .out_ready_i, .out_data_o,
    .ovf_event_o, .ovf_flag_o, .short_line_o);
  always @(posedge clock_i) begin
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      got.push_back(out_data_o);
    end
    if (ovf_event_o === 1'b1) begin
      ovf_cnt++;
    end
  end
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_out(input int n);
    int k;
    k = 0;
    while (got.size() < n && k < 60) begin
      @(posedge clock_i);
      k++;
    end
    if (got.size() < n) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic clear_flags;
    @(posedge clock_i);
    ovf_clear_i <= 1'b1;
    @(posedge clock_i);
    ovf_clear_i <= 1'b0;
  endtask
  task automatic pass_order;
    out_ready_i <= 1'b1;
    video_source_inst.send_line(9, 24'h000100, 24'h000001);
    wait_out(9);
    for (int i = 0; i < 9; i++) `CHK(got[i], 24'h000100 + 24'(i))
    `CHK(ovf_cnt, 0)
    `CHK(ovf_flag_o, 1'b0)
  endtask
  // Receiver stalls: every pixel is either stored or dropped
  task automatic overflow_drop;
    int n;
    got.delete();
    out_ready_i <= 1'b0;
    video_source_inst.send_line(12, 24'h00A000, 24'h000001);
    settle(4);
    `CHK(ovf_flag_o, 1'b1)
    n = ovf_cnt;
    `CHK(n > 0, 1'b1)
    // Four buffer words plus two skid entries hold, the rest are dropped
    `CHK(n, 6)
    @(posedge clock_i);
    out_ready_i <= 1'b1;
    wait_out(12 - n);
    settle(10);
    `CHK(got.size() + n, 12)
    `CHK(got[0], 24'h00A000)
    for (int i = 1; i < 6; i++) `CHK(got[i], 24'h00A000 + 24'(i))
    `CHK(ovf_flag_o, 1'b1)
    clear_flags();
    settle(1);
    `CHK(ovf_flag_o, 1'b0)
  endtask
  // Neutral pixels: any colour matrix keeps grey and centred chroma
  task automatic convert_neutral;
    got.delete();
    mode_i <= 2'h1;
    video_source_inst.send_line(9, 24'hFFFFFF, 24'h000000);
    wait_out(9);
    for (int i = 0; i < 9; i++) `CHK(got[i], 24'h00FF80)
    got.delete();
    mode_i <= 2'h2;
    video_source_inst.send_line(4, 24'h004080, 24'h000000);
    wait_out(4);
    settle(2);
    for (int i = 0; i < 4; i++) `CHK(got[i], 24'h404040)
    `CHK(short_line_o, 1'b0)
  endtask
  task automatic short_lines;
    int md[6] = '{1, 1, 2, 2, 1, 0};
    int ln[6] = '{8, 9, 3, 4, 5, 2};
    int mc[6] = '{0, 0, 0, 0, 1, 0};
    int ex[6] = '{1, 0, 1, 0, 0, 0};
    for (int i = 0; i < 6; i++) begin
      clear_flags();
      mode_i <= 2'(md[i]);
      multi_chan_i <= 1'(mc[i]);
      video_source_inst.send_line(ln[i], 24'h808080, 24'h000000);
      settle(6);
      `CHK(short_line_o, 1'(ex[i]))
      `CHK(ovf_flag_o, 1'b0)
    end
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    pass_order();
    overflow_drop();
    convert_neutral();
    short_lines();
    end_sim();
  end
endmodule

// File: verif/video_source.sv
`timescale 1ns/1ps
// Far-side pixel source; the bench picks each line length
module video_source (
  input wire logic clock_i,
  output logic pix_valid_o,
  output logic [23:0] pix_data_o,
  output logic pix_eol_o
);
  initial begin
    pix_valid_o = 1'b0;
    pix_data_o = 24'h000000;
    pix_eol_o = 1'b0;
  end
  // Back to back pixels; idle data is inverted so it carries nothing
  task automatic send_line(input int n, input logic [23:0] base,
                           input logic [23:0] step);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      pix_valid_o <= 1'b1;
      pix_data_o <= base + 24'(i) * step;
      pix_eol_o <= (i == n - 1);
    end
    @(posedge clock_i);
    pix_valid_o <= 1'b0;
    pix_eol_o <= 1'b0;
    pix_data_o <= ~pix_data_o;
  endtask
endmodule
